// ==== include/adram_consts.vh ====
`ifndef ADRAM_CONSTS_VH
`define ADRAM_CONSTS_VH
// Clock period in picoseconds (50 MHz).
`define ADRAM_CLK_PS        20000
// Timing figures in nanoseconds for the fastest grade.
`define ADRAM_CYCLE_NS      140
`define ADRAM_T_RP_NS       60
`define ADRAM_ROW_COL_NS    20
`define ADRAM_ROW_HOLD_NS   10
`define ADRAM_T_CAS_NS      43
`define ADRAM_T_WP_NS       15
`define ADRAM_T_CSR_NS      10
// Power-up pause in microseconds and refresh period in milliseconds.
`define ADRAM_T_PAUSE_US    200
`define ADRAM_REFRESH_MS    64
`define ADRAM_REF_ROWS      512
`define ADRAM_INIT_CYCLES   8
// Address split widths and timer width.
`define ADRAM_ROW_W         10
`define ADRAM_COL_W         10
`define ADRAM_ADDR_W        20
`define ADRAM_TMR_W         24
`endif

// ==== design/adram_ctrl.v ====
`timescale 1ns/1ps
`include "adram_consts.vh"
// Overview of operation
// - Present row, drop row strobe, then present column, drop column strobe.
// - Row and column addresses are stable before their strobe falls.
// - Early write: write strobe falls before column strobe, it captures.
// - Issue 512 refresh cycles covering all rows within every 64 ms.
// - Shared data wire is legal only when writes are all early.
// - Random cycles start no more often than once per 140 ns.
// - After power-up pause 200 us, then eight refresh cycles.
module adram_ctrl #(
    parameter PAUSE_CYC = (`ADRAM_T_PAUSE_US * 1000000) / `ADRAM_CLK_PS,
    parameter REF_CYC   = ((`ADRAM_REFRESH_MS * 1000000) / `ADRAM_REF_ROWS)
                          / (`ADRAM_CLK_PS / 1000)
) (
    input  wire                     i_ref_clk,
    input  wire                     i_resetn,
    input  wire                     i_req_valid,
    input  wire                     i_req_write,
    input  wire [`ADRAM_ADDR_W-1:0] i_req_addr,
    input  wire                     i_req_wdata,
    output wire                     o_req_ready,
    output reg                      o_rsp_valid,
    output reg                      o_rsp_rdata,
    output reg                      o_init_done,
    output reg  [`ADRAM_ROW_W-1:0]  o_multiplexed_address,
    output reg                      o_row_strobe_n,
    output reg                      o_col_strobe_n,
    output reg                      o_write_strobe_n,
    output reg                      o_dram_din,
    input  wire                     i_dram_dout
);
    // Cycle counts; minimums round up, none below one.
    // The column strobe stays low one cycle past the column access time so
    // the sampled bit has settled, at the cost of 20 ns per access.
    localparam CLK_NS    = `ADRAM_CLK_PS / 1000;
    localparam ROW_COL_C = (`ADRAM_ROW_COL_NS + CLK_NS - 1) / CLK_NS;
    localparam CAS_C     = (`ADRAM_T_CAS_NS + CLK_NS - 1) / CLK_NS + 1;
    localparam RP_C      = (`ADRAM_T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam CYCLE_C   = (`ADRAM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam RAS_C     = CYCLE_C - RP_C;
    localparam CSR_C     = (`ADRAM_T_CSR_NS + CLK_NS - 1) / CLK_NS;

    // Sequencer states. Pause, refresh and access share one timer, so
    // only one of them can be in progress at any time.
    localparam [3:0] S_PAUSE = 4'h0;
    localparam [3:0] S_IDLE  = 4'h1;
    localparam [3:0] S_ROW   = 4'h2;
    localparam [3:0] S_COL   = 4'h3;
    localparam [3:0] S_CAS   = 4'h4;
    localparam [3:0] S_RASH  = 4'h5;
    localparam [3:0] S_PRE   = 4'h6;
    localparam [3:0] S_CBR   = 4'h7;
    localparam [3:0] S_CBRR  = 4'h8;

    // Sequencer state and its countdown timer; zero ends the wait.
    reg [3:0]              state_q;
    reg [`ADRAM_TMR_W-1:0] tmr_q;
    // Refresh interval counter and the flag that says one is owed.
    reg [`ADRAM_TMR_W-1:0] ref_tmr_q;
    reg                    ref_pend_q;
    // Init progress: one as the pause starts, plus one per refresh, up to 9.
    reg [3:0]              init_cnt_q;
    // Access kept for the column phase: direction and column half.
    reg                    wr_q;
    reg [`ADRAM_COL_W-1:0] col_q;
    wire tmr_done = (tmr_q == {`ADRAM_TMR_W{1'b0}});

    // Requests are only taken between cycles with no refresh owed, and
    // never before initialisation is complete. Gating on the init flag
    // keeps ready low in the idle cycle between two init refreshes, where
    // the sequencer would start a refresh and drop the request.
    assign o_req_ready = (state_q == S_IDLE) && !ref_pend_q && tmr_done
                         && o_init_done;

    // Refresh interval timer; the owed flag wins over its own clear.
    // The counter free-runs from reset, so refresh keeps its pace even
    // while accesses are waiting; a late refresh only delays ready.
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ref_tmr_q  <= {`ADRAM_TMR_W{1'b0}};
            ref_pend_q <= 1'b0;
        end else begin
            if (ref_tmr_q == REF_CYC[`ADRAM_TMR_W-1:0] - 1'b1) begin
                ref_tmr_q  <= {`ADRAM_TMR_W{1'b0}};
                ref_pend_q <= 1'b1;
            end else begin
                ref_tmr_q <= ref_tmr_q + 1'b1;
                if (state_q == S_CBR)
                    ref_pend_q <= 1'b0;
            end
        end
    end

    // Main sequencer. Column-before-row refresh is used throughout, so the
    // device counter walks the rows and no refresh address is kept here.
    always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q               <= S_PAUSE;
            tmr_q                 <= {`ADRAM_TMR_W{1'b0}};
            init_cnt_q            <= 4'h0;
            wr_q                  <= 1'b0;
            col_q                 <= {`ADRAM_COL_W{1'b0}};
            o_rsp_valid           <= 1'b0;
            o_rsp_rdata           <= 1'b0;
            o_init_done           <= 1'b0;
            o_multiplexed_address <= {`ADRAM_ROW_W{1'b0}};
            o_row_strobe_n        <= 1'b1;
            o_col_strobe_n        <= 1'b1;
            o_write_strobe_n      <= 1'b1;
            o_dram_din            <= 1'b0;
        end else begin
            o_rsp_valid <= 1'b0;
            if (!tmr_done)
                tmr_q <= tmr_q - 1'b1;
            case (state_q)
                S_PAUSE: begin
                    // Both strobes held high through the pause.
                    if (tmr_q == {`ADRAM_TMR_W{1'b0}} && init_cnt_q == 4'h0)
                    begin
                        tmr_q      <= PAUSE_CYC[`ADRAM_TMR_W-1:0];
                        init_cnt_q <= 4'h1;
                    end else if (tmr_done) begin
                        state_q <= S_CBR;
                    end
                end
                S_IDLE: begin
                    // Refresh and initialisation win over a waiting request.
                    if (tmr_done && (ref_pend_q ||
                        init_cnt_q < `ADRAM_INIT_CYCLES + 1)) begin
                        state_q <= S_CBR;
                    end else if (o_req_ready && i_req_valid) begin
                        // Row half first, column half kept.
                        o_multiplexed_address <=
                            i_req_addr[`ADRAM_ADDR_W-1:`ADRAM_COL_W];
                        col_q      <= i_req_addr[`ADRAM_COL_W-1:0];
                        wr_q       <= i_req_write;
                        o_dram_din <= i_req_wdata;
                        state_q    <= S_ROW;
                    end
                end
                S_ROW: begin
                    // Address stood one cycle before the strobe falls.
                    o_row_strobe_n <= 1'b0;
                    // The row stays on the pins one more cycle, past its
                    // hold interval, before the column replaces it.
                    tmr_q          <= ROW_COL_C[`ADRAM_TMR_W-1:0];
                    state_q        <= S_COL;
                end
                S_COL: begin
                    // Column presented after the row hold interval.
                    o_multiplexed_address <= col_q;
                    // Write strobe falls ahead of column: early write, so
                    // delayed writes never occur.
                    o_write_strobe_n <= !wr_q;
                    if (tmr_done) begin
                        state_q <= S_CAS;
                    end
                end
                S_CAS: begin
                    o_col_strobe_n <= 1'b0;
                    tmr_q          <= CAS_C[`ADRAM_TMR_W-1:0];
                    state_q        <= S_RASH;
                end
                S_RASH: begin
                    if (tmr_done) begin
                        // Sample read data after column access time. The
                        // strobes rise on this same edge, so the device
                        // lets go of its output only after the sample.
                        o_rsp_rdata      <= i_dram_dout;
                        o_rsp_valid      <= 1'b1;
                        o_row_strobe_n   <= 1'b1;
                        o_col_strobe_n   <= 1'b1;
                        o_write_strobe_n <= 1'b1;
                        tmr_q            <= RP_C[`ADRAM_TMR_W-1:0];
                        state_q          <= S_PRE;
                    end
                end
                S_PRE: begin
                    // Precharge plus one idle cycle keeps spacing.
                    if (tmr_done)
                        state_q <= S_IDLE;
                end
                S_CBR: begin
                    // Column strobe low ahead of row strobe.
                    o_col_strobe_n <= 1'b0;
                    tmr_q          <= CSR_C[`ADRAM_TMR_W-1:0];
                    state_q        <= S_CBRR;
                end
                S_CBRR: begin
                    if (tmr_done && o_row_strobe_n) begin
                        o_row_strobe_n <= 1'b0;
                        tmr_q          <= RAS_C[`ADRAM_TMR_W-1:0];
                    end else if (tmr_done) begin
                        o_row_strobe_n <= 1'b1;
                        o_col_strobe_n <= 1'b1;
                        tmr_q          <= RP_C[`ADRAM_TMR_W-1:0];
                        if (init_cnt_q < `ADRAM_INIT_CYCLES + 1)
                            init_cnt_q <= init_cnt_q + 1'b1;
                        // The eighth refresh since reset ends initialisation.
                        if (init_cnt_q >= `ADRAM_INIT_CYCLES)
                            o_init_done <= 1'b1;
                        state_q <= S_PRE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // adram_ctrl

// ==== dv/adram_ctrl_properties.sv ====
`timescale 1ns/1ps
module adram_ctrl_properties (
    input wire       i_ref_clk,
    input wire       i_resetn,
    input wire       o_req_ready,
    input wire       o_rsp_valid,
    input wire       o_init_done,
    input wire [9:0] o_multiplexed_address,
    input wire       o_row_strobe_n,
    input wire       o_col_strobe_n,
    input wire       o_write_strobe_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // Access opens with the row; refresh drops the column strobe first.
    sequence s_open;
        $fell(o_row_strobe_n) && o_col_strobe_n;
    endsequence
    sequence s_col_fall;
        $fell(o_col_strobe_n) && !o_row_strobe_n;
    endsequence
    sequence s_cbr;
        $fell(o_col_strobe_n) && o_row_strobe_n;
    endsequence
    // Row strobe follows two cycles later and stays low for five samples.
    sequence s_cbr_body;
        (o_row_strobe_n && !o_col_strobe_n) ##1
        (!o_row_strobe_n && !o_col_strobe_n)[*5] ##1
        (o_row_strobe_n && o_col_strobe_n);
    endsequence
    property p_row_before_col;
        s_open |-> ##[1:3] s_col_fall;
    endproperty
    property p_addr_stable;
        (s_open or s_col_fall) |-> $stable(o_multiplexed_address);
    endproperty
    property p_write_early;
        $fell(o_write_strobe_n) |-> o_col_strobe_n;
    endproperty
    property p_rsp_pulse;
        o_rsp_valid |-> o_row_strobe_n ##1 !o_rsp_valid;
    endproperty
    property p_ready_idle;
        o_req_ready |-> o_row_strobe_n && o_col_strobe_n;
    endproperty
    chk_row_before_col: assert property (p_row_before_col)
        else $error("column strobe late after row strobe");
    chk_addr_stable: assert property (p_addr_stable)
        else $error("address moved at its strobe edge");
    chk_write_early: assert property (p_write_early)
        else $error("write strobe fell after column strobe");
    chk_cbr_pulse: assert property (s_cbr |=> s_cbr_body)
        else $error("refresh pulse shape wrong");
    chk_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response not a single pulse with row closed");
    chk_ready_gap: assert property (o_rsp_valid |-> (!o_req_ready)[*4])
        else $error("ready too soon after response");
    chk_ready_init: assert property (!o_init_done |-> !o_req_ready)
        else $error("ready before init done");
    chk_ready_idle: assert property (p_ready_idle)
        else $error("ready while a strobe is low");
endmodule // adram_ctrl_properties
bind adram_ctrl adram_ctrl_properties chk_u (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_init_done(o_init_done),
    .o_multiplexed_address(o_multiplexed_address),
    .o_row_strobe_n(o_row_strobe_n), .o_col_strobe_n(o_col_strobe_n),
    .o_write_strobe_n(o_write_strobe_n));

// ==== dv/adram_dev_model.sv ====
`timescale 1ns/1ps
module adram_dev_model (
    input  wire [9:0] i_multiplexed_address,
    input  wire       i_row_strobe_n,
    input  wire       i_col_strobe_n,
    input  wire       i_write_strobe_n,
    input  wire       i_din,
    output reg        o_dout
);
    reg       mem [0:20'hFFFFF];
    reg [9:0] row_q;
    reg [9:0] ctr_q = 10'h000;
    reg       cbr_q = 1'b0;
    initial o_dout = 1'b0;
    // Row fall latches the row, or counts a refresh if column is low. The
    // output is left alone, so a hidden refresh keeps the last read bit.
    always @(negedge i_row_strobe_n) begin
        cbr_q = !i_col_strobe_n;
        if (cbr_q) ctr_q = ctr_q + 10'h001;
        else row_q = i_multiplexed_address;
    end
    // Column fall writes on a low write strobe, otherwise reads the cell.
    always @(negedge i_col_strobe_n) if (!i_row_strobe_n && !cbr_q) begin
        if (!i_write_strobe_n) mem[{row_q, i_multiplexed_address}] = i_din;
        else o_dout = mem[{row_q, i_multiplexed_address}];
    end
    // Released output shows the inverse, so stale data never passes.
    always @(posedge i_col_strobe_n) o_dout = ~o_dout;
endmodule // adram_dev_model

// ==== dv/adram_ctrl_tb.sv ====
`timescale 1ns/1ps
module adram_ctrl_tb;
    reg        i_ref_clk = 1'b0;
    reg        i_resetn = 1'b0;
    reg        i_req_valid = 1'b0;
    reg        i_req_write = 1'b0;
    reg [19:0] i_req_addr = 20'h00000;
    reg        i_req_wdata = 1'b0;
    wire       o_req_ready, o_rsp_valid, o_rsp_rdata, o_init_done;
    wire [9:0] o_multiplexed_address;
    wire       o_row_strobe_n, o_col_strobe_n, o_write_strobe_n;
    wire       o_dram_din, i_dram_dout;
    integer    err_count = 0, check_count = 0, cbr_n = 0;
    // Short pause and refresh interval keep the run brief.
    adram_ctrl #(.PAUSE_CYC(50), .REF_CYC(200)) dut_u (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
        .i_req_write(i_req_write), .i_req_addr(i_req_addr),
        .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready),
        .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
        .o_init_done(o_init_done), .o_multiplexed_address(o_multiplexed_address),
        .o_row_strobe_n(o_row_strobe_n), .o_col_strobe_n(o_col_strobe_n),
        .o_write_strobe_n(o_write_strobe_n), .o_dram_din(o_dram_din),
        .i_dram_dout(i_dram_dout));
    adram_dev_model mem_u (.i_multiplexed_address(o_multiplexed_address),
        .i_row_strobe_n(o_row_strobe_n), .i_col_strobe_n(o_col_strobe_n),
        .i_write_strobe_n(o_write_strobe_n), .i_din(o_dram_din),
        .o_dout(i_dram_dout));
    // Clock, and a count of refreshes seen with the row still closed.
    always #10 i_ref_clk = ~i_ref_clk;
    always @(negedge o_col_strobe_n) if (o_row_strobe_n) cbr_n = cbr_n + 1;
    task check(input logic [19:0] seen, input logic [19:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One access; request held until the edge where ready is high.
    task acc(input logic w, input logic [19:0] a, input logic d,
             output logic q);
        integer n;
        begin
            n = 0;
            @(posedge i_ref_clk);
            i_req_valid <= 1'b1;
            i_req_write <= w;
            i_req_addr <= a;
            i_req_wdata <= d;
            @(negedge i_ref_clk);
            while (o_req_ready !== 1'b1 && n < 500) begin
                @(negedge i_ref_clk);
                n = n + 1;
            end
            @(posedge i_ref_clk);
            i_req_valid <= 1'b0;
            while (o_rsp_valid !== 1'b1 && n < 600) begin
                @(negedge i_ref_clk);
                n = n + 1;
            end
            check(o_rsp_valid, 20'h00001);
            q = o_rsp_rdata;
        end
    endtask
    task t_init;
        integer n;
        begin
            n = 0;
            repeat (40) @(posedge i_ref_clk);
            check(cbr_n, 20'h00000);
            check(o_init_done, 20'h00000);
            while (o_init_done !== 1'b1 && n < 400) begin
                @(negedge i_ref_clk);
                n = n + 1;
            end
            check(cbr_n, 20'h00008);
            $display("test init finished");
        end
    endtask
    // Write sixteen cells from first to last address, then read them.
    task t_data;
        integer k;
        logic   q;
        for (k = 0; k < 32; k = k + 1) begin
            acc(k < 16, k[3:0] * 20'h11111, k[0] ^ k[1], q);
            if (k >= 16) check(q, k[0] ^ k[1]);
        end
        $display("test data finished");
    endtask
    // Idle span of 450 cycles must hold two or three refreshes.
    task t_refresh;
        integer c0;
        begin
            c0 = cbr_n;
            repeat (450) @(posedge i_ref_clk);
            check(cbr_n - c0 >= 2 && cbr_n - c0 <= 3, 20'h00001);
            $display("test refresh finished");
        end
    endtask
    task wrap_up;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence after four cycles of reset.
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        t_init;
        t_data;
        t_refresh;
        wrap_up;
    end
    // Watchdog: the tests need about 1100 cycles, so 20000 means a hang.
    initial begin
        #400000;
        err_count = err_count + 1;
        wrap_up;
    end
endmodule // adram_ctrl_tb
